// *** shared/mds_pkg.sv ***
// Shared constants for the motor driver serial port: frame layout,
// byte tags, chain limits and link timing.
// Assumes both ends run on a 250 MHz system clock.
`default_nettype none
package mds_pkg;
  // System clock period
  localparam int CLK_NS = 4;
  // Bits in one single-device frame and in one byte
  localparam int FRAME_BITS = 16;
  localparam int BYTE_BITS = 8;
  // Top two bits that tag status and header bytes
  localparam logic [1:0] STATUS_TAG = 2'h3;
  localparam logic [1:0] HDR_TAG = 2'h2;
  // Field positions inside a command (address) byte
  localparam int CMD_ZERO_POS = 7;
  localparam int RW_POS = 6;
  localparam int ADDR_MSB = 5;
  localparam int ADDR_LSB = 1;
  // Clear-all position inside the control header
  localparam int CLR_POS = 5;
  // Widths of chain length, register address and fault set
  localparam int CHAIN_W = 6;
  localparam int ADDR_W = 5;
  localparam int FAULT_W = 6;
  // Falling-edge counter width, holds 64 devices of 16 bits
  localparam int FALL_W = 11;
  // Integrity pattern put in the low bits of the control header
  localparam logic [4:0] CHECK_PATTERN = 5'h15;
  // Serial clock half period and idle gap between frames
  localparam int SCLK_HALF_NS = 80;
  localparam int GAP_NS = 500;
  localparam int HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  // Width of the host timing counter
  localparam int TMR_W = 7;
endpackage : mds_pkg
`default_nettype wire

// *** shared/mds_link_if.sv ***
// Four-wire serial link between one host and one device.
// The serial output is resolved here; an idle line reads high.
`default_nettype none
interface mds_link_if;
  // Host driven lines
  logic frame_select_n;
  logic sclk;
  logic sdi;
  // Device driven line and its enable
  logic sdo;
  logic sdo_oe;
  // Resolved serial output as the host sees it
  logic sdo_line;
  assign sdo_line = sdo_oe ? sdo : 1'b1;
  // Device end
  modport device (
    input frame_select_n,
    input sclk,
    input sdi,
    output sdo,
    output sdo_oe
  );
  // Host end
  modport host (
    output frame_select_n,
    output sclk,
    output sdi,
    input sdo_line
  );
endinterface : mds_link_if
`default_nettype wire

// *** logic/mds_dev_end.sv ***
// Device end of the serial port: frame decode, status and report output,
// chain pass-through, write and clear-all strobes toward a register file.
// Assumes a register file that answers reg_addr combinationally.
`default_nettype none
// Notes on behaviour
// R1 - Input word: zero, rw, address, ignored, data
// R2 - Output word: status byte then report byte
// R3 - Status byte: 11 then six fault flags
// R4 - Write returns register value before the write
// R5 - Read returns contents, register unchanged
// R6 - Host keeps clock low at select edges
// R7 - Host waits 500 ns between frames
// R8 - Deselected: ignore inputs, output released
// R9 - Sample on falling, change on rising
// R10 - Most significant bit first both ways
// R11 - Wrong clock count: frame error, word dropped
// R12 - Parallel devices: own select each
// R13 - Host sends headers, addresses, then data
// R14 - Chain returns statuses, headers, then reports
// R15 - First header holds six-bit device count
// R16 - Host starts header bytes with 10
// R17 - Control header low bits pass unchanged
// R18 - Clear-all clears faults at select rise
// R19 - Position from status bytes before header
// R20 - Take own bytes, pass others through
// R21 - Chain address and data bytes as single
// R22 - Sleep low disables the port
// R23 - Fault flags sampled at select fall
module mds_dev_end
  import mds_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  mds_link_if.device bus,
  input wire logic sleep_request_n,
  input wire logic temp_warning_flag,
  input wire logic supply_low_flag,
  input wire logic pump_low_flag,
  input wire logic overcurrent_flag,
  input wire logic thermal_shutdown_flag,
  input wire logic open_load_flag,
  output logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic fault_clear,
  output logic frame_error,
  output logic [CHAIN_W-1:0] chain_position,
  output logic [CHAIN_W-1:0] chain_length
);
  // Port states, Gray coded
  typedef enum logic [1:0] {
    DS_IDLE = 2'h0,
    DS_ACTIVE = 2'h1,
    DS_SKIP = 2'h3
  } mds_dev_st_t;

  // Whole state of the device end
  typedef struct packed {
    logic [3:0] s1;                 // First sync stage {sleep, sdi, sclk, cs}
    logic [3:0] s2;                 // Second sync stage
    logic sclk_prev;                // Clock level one cycle ago
    mds_dev_st_t st;                // Port state
    logic [FALL_W-1:0] falls;       // Falling edges in this frame
    logic [7:0] in_sh;              // Incoming bits
    logic [7:0] in_last;            // Last whole byte received
    logic [7:0] out_sh;             // Outgoing byte, MSB on the line
    logic [7:0] status;             // Status byte frozen for the frame
    logic chain;                    // Frame is a chain frame
    logic chain_count_header;                     // Count header seen
    logic chain_control_header;                     // Control header seen
    logic bad;                      // Chain byte out of place
    logic [CHAIN_W-1:0] pos;        // Status bytes before the header
    logic [CHAIN_W-1:0] len;        // Devices in the chain
    logic clr;                      // Clear-all requested
    logic [7:0] cmd;                // Own command byte
    logic [7:0] data;               // Own data byte
    logic wr;                       // Write strobe
    logic fclr;                     // Fault clear strobe
    logic ferr;                     // Frame error strobe
  } mds_dev_reg_t;

  mds_dev_reg_t q, d;
  logic rise;          // Serial clock rising edge seen
  logic fall;          // Serial clock falling edge seen
  logic [7:0] nb;      // Byte formed by the current falling edge
  logic [7:0] idx;     // Whole bytes so far
  logic [7:0] nxt;     // Byte to start on a byte boundary
  logic chain_now;     // Chain decision including the current byte
  logic ok;            // Frame good at its end

  // Next-state logic
  always_comb
  begin
    d = q;
    d.wr = 1'b0;
    d.fclr = 1'b0;
    d.ferr = 1'b0;
    d.s1 = {sleep_request_n, bus.sdi, bus.sclk, bus.frame_select_n};
    d.s2 = q.s1;
    d.sclk_prev = q.s2[1];
    rise = q.s2[1] & ~q.sclk_prev;
    fall = ~q.s2[1] & q.sclk_prev;
    nb = {q.in_sh[6:0], q.s2[2]}; // R10
    idx = q.falls[FALL_W-1:3];
    chain_now = (idx == 8'h00) ? nb[7] : q.chain;
    // Choose the byte that starts at this boundary
    if (idx == 8'h00)
    begin
      nxt = q.status; // R2
    end
    else if (!q.chain)
    begin
      nxt = (idx == 8'h01) ? reg_rdata : 8'h00; // R2 R4 R5
    end
    else if (q.chain_control_header && idx == {2'h0, q.len} + 8'h02)
    begin
      nxt = reg_rdata; // R14 R20
    end
    else
    begin
      nxt = q.in_last; // R14 R17 R20
    end
    // Frame check at the end of select
    if (!q.chain)
    begin
      ok = q.falls == FALL_W'(FRAME_BITS) && !q.cmd[CMD_ZERO_POS]; // R1 R11
    end
    else
    begin
      ok = q.chain_control_header && !q.bad && q.len != '0 && q.pos < q.len
        && !q.cmd[CMD_ZERO_POS]
        && q.falls == FALL_W'({q.len, 4'h0}) + FALL_W'(FRAME_BITS); // R11 R15
    end
    unique case (q.st)
      DS_IDLE:
      begin
        // Start of frame, or ignore it while asleep
        if (!q.s2[0])
        begin
          if (q.s2[3])
          begin
            d.st = DS_ACTIVE;
            d.falls = '0;
            d.out_sh = 8'h00;
            d.chain = 1'b0;
            d.chain_count_header = 1'b0;
            d.chain_control_header = 1'b0;
            d.bad = 1'b0;
            d.pos = '0;
            d.len = '0;
            d.clr = 1'b0;
            d.cmd = 8'h00;
            d.status = {STATUS_TAG, temp_warning_flag, supply_low_flag,
              pump_low_flag, overcurrent_flag, thermal_shutdown_flag,
              open_load_flag}; // R3 R23
          end
          else
          begin
            d.st = DS_SKIP; // R22
          end
        end
      end
      DS_SKIP:
      begin
        // Wait for deselect before watching again
        if (q.s2[0])
        begin
          d.st = DS_IDLE; // R8
        end
      end
      DS_ACTIVE:
      begin
        if (!q.s2[3])
        begin
          d.st = DS_SKIP; // R22
        end
        else if (q.s2[0])
        begin
          // End of frame: commit or report an error
          d.st = DS_IDLE;
          if (ok)
          begin
            d.wr = !q.cmd[RW_POS]; // R4 R5
            d.fclr = q.chain && q.clr; // R18
          end
          else
          begin
            d.ferr = 1'b1; // R11
          end
        end
        else
        begin
          // Drive on the rising edge
          if (rise)
          begin
            if (q.falls[2:0] == 3'h0)
            begin
              d.out_sh = nxt; // R9
            end
            else
            begin
              d.out_sh = {q.out_sh[6:0], 1'b0}; // R9 R10
            end
          end
          // Sample on the falling edge
          if (fall)
          begin
            d.in_sh = nb; // R9
            if (!(&q.falls))
            begin
              d.falls = q.falls + FALL_W'(1);
            end
            if (q.falls[2:0] == 3'h7)
            begin
              d.in_last = nb;
              d.chain = chain_now;
              if (!chain_now)
              begin
                // Single frame: command byte then data byte
                if (idx == 8'h00)
                begin
                  d.cmd = nb; // R1
                end
                if (idx == 8'h01)
                begin
                  d.data = nb; // R1
                end
              end
              else if (!q.chain_count_header)
              begin
                // Count status bytes until the count header
                if (nb[7:6] == STATUS_TAG)
                begin
                  d.bad = q.bad | (&q.pos);
                  d.pos = q.pos + CHAIN_W'(1); // R19
                end
                else if (nb[7:6] == HDR_TAG)
                begin
                  d.chain_count_header = 1'b1;
                  d.len = nb[CHAIN_W-1:0]; // R15 R19
                end
                else
                begin
                  d.bad = 1'b1;
                end
              end
              else if (!q.chain_control_header)
              begin
                // Control header
                d.chain_control_header = 1'b1;
                d.clr = nb[CLR_POS]; // R18
                d.bad = q.bad | (nb[7:6] != HDR_TAG);
              end
              else
              begin
                // Own address and data bytes
                if (idx == {2'h0, q.len} + 8'h01)
                begin
                  d.cmd = nb; // R20 R21
                end
                if (idx == {1'b0, q.len, 1'b1})
                begin
                  d.data = nb; // R20 R21
                end
              end
            end
          end
        end
      end
      default:
      begin
        d.st = DS_SKIP;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs
  assign bus.sdo = q.out_sh[7];
  assign bus.sdo_oe = (q.st == DS_ACTIVE); // R8 R12 R22
  assign reg_addr = q.cmd[ADDR_MSB:ADDR_LSB];
  assign reg_wr = q.wr;
  assign reg_wdata = q.data;
  assign fault_clear = q.fclr;
  assign frame_error = q.ferr;
  assign chain_position = q.pos;
  assign chain_length = q.len;
endmodule : mds_dev_end
`default_nettype wire

// *** logic/mds_host_end.sv ***
// Host end of the serial port: makes the serial clock by division,
// frames single 16-bit words or whole chain transfers with headers.
// Assumes the user offers each payload byte when tx_take pulses.
`default_nettype none
module mds_host_end
  import mds_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  mds_link_if.host bus,
  input wire logic start,
  input wire logic [CHAIN_W-1:0] chain_len,
  input wire logic clear_all,
  input wire logic [7:0] tx_byte,
  output logic tx_take,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic busy,
  output logic done
);
  // Host states, Gray coded along the frame
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_SETUP = 3'h1,
    HS_HIGH = 3'h3,
    HS_LOW = 3'h2,
    HS_HOLD = 3'h6,
    HS_GAP = 3'h4
  } mds_host_st_t;

  // Whole state of the host end
  typedef struct packed {
    logic s1;                 // First sync stage of the serial output
    logic s2;                 // Second sync stage
    mds_host_st_t st;         // Host state
    logic [TMR_W-1:0] tmr;    // Cycles in the present phase
    logic [2:0] bitn;         // Bit within the byte
    logic [7:0] byte_i;       // Byte within the frame
    logic [7:0] nbytes;       // Bytes in this frame
    logic chain;              // Chain transfer
    logic [CHAIN_W-1:0] len;  // Devices in the chain
    logic clr;                // Clear-all request
    logic [7:0] tx_sh;        // Rest of the outgoing byte
    logic [7:0] rx_sh;        // Incoming bits
    logic sel;                // Frame select asserted
    logic sclk;               // Serial clock level
    logic sdi;                // Serial data to the device
    logic [7:0] rx_byte;      // Last byte received
    logic rx_valid;           // Byte strobe
    logic done;               // Frame done strobe
  } mds_host_reg_t;

  mds_host_reg_t q, d;
  logic do_rise;       // Raise the clock this cycle
  logic half_up;       // Half period over
  logic [7:0] src;     // Byte to start
  logic [7:0] rxn;     // Byte formed by this falling edge

  // Next-state logic
  always_comb
  begin
    d = q;
    d.rx_valid = 1'b0;
    d.done = 1'b0;
    d.s1 = bus.sdo_line;
    d.s2 = q.s1;
    d.tmr = q.tmr + TMR_W'(1);
    half_up = (q.tmr == TMR_W'(HALF_CYC - 1));
    do_rise = 1'b0;
    tx_take = 1'b0;
    rxn = {q.rx_sh[6:0], q.s2}; // R10
    // Headers come from the host itself, payload from the user
    if (q.chain && q.byte_i == 8'h00)
    begin
      src = {HDR_TAG, q.len}; // R13 R15 R16
    end
    else if (q.chain && q.byte_i == 8'h01)
    begin
      src = {HDR_TAG, q.clr, CHECK_PATTERN}; // R16 R17 R18
    end
    else
    begin
      src = tx_byte;
    end
    unique case (q.st)
      HS_IDLE:
      begin
        d.tmr = '0;
        if (start)
        begin
          d.chain = (chain_len != '0);
          d.len = chain_len;
          d.clr = clear_all;
          d.nbytes = (chain_len != '0) ? {1'b0, chain_len, 1'b0} + 8'h02 : 8'h02; // R11 R13
          d.byte_i = 8'h00;
          d.bitn = 3'h0;
          d.sel = 1'b1; // R6
          d.st = HS_SETUP;
        end
      end
      HS_SETUP, HS_LOW:
      begin
        do_rise = half_up;
      end
      HS_HIGH:
      begin
        // Falling edge: sample the device output
        if (half_up)
        begin
          d.sclk = 1'b0;
          d.tmr = '0;
          d.rx_sh = rxn; // R9
          d.bitn = q.bitn + 3'h1;
          d.st = HS_LOW;
          if (q.bitn == 3'h7)
          begin
            d.rx_byte = rxn;
            d.rx_valid = 1'b1;
            d.byte_i = q.byte_i + 8'h01;
            if (q.byte_i == q.nbytes - 8'h01)
            begin
              d.st = HS_HOLD; // R11
            end
          end
        end
      end
      HS_HOLD:
      begin
        // Clock stays low through the select rise
        if (half_up)
        begin
          d.sel = 1'b0; // R6
          d.tmr = '0;
          d.st = HS_GAP;
        end
      end
      HS_GAP:
      begin
        // Minimum deselect time
        if (q.tmr == TMR_W'(GAP_CYC - 1))
        begin
          d.st = HS_IDLE; // R7
          d.done = 1'b1;
        end
      end
      default:
      begin
        d.st = HS_IDLE;
      end
    endcase
    // Rising edge: present the next bit
    if (do_rise)
    begin
      d.sclk = 1'b1;
      d.tmr = '0;
      d.st = HS_HIGH;
      if (q.bitn == 3'h0)
      begin
        tx_take = !(q.chain && q.byte_i < 8'h02);
        d.sdi = src[7]; // R9 R10
        d.tx_sh = {src[6:0], 1'b0};
      end
      else
      begin
        d.sdi = q.tx_sh[7]; // R9 R10
        d.tx_sh = {q.tx_sh[6:0], 1'b0};
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs
  assign bus.frame_select_n = ~q.sel; // R12
  assign bus.sclk = q.sclk;
  assign bus.sdi = q.sdi;
  assign rx_byte = q.rx_byte;
  assign rx_valid = q.rx_valid;
  assign busy = (q.st != HS_IDLE);
  assign done = q.done;
endmodule : mds_host_end
`default_nettype wire

// *** sim/mds_link_chk.sv ***
// Checker on one serial link between a host end and a device end.
// Assumes plain interface signals from the bench and one system clock.
`default_nettype none
module mds_link_chk
  import mds_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic frame_select_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sdo_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Falls seen in this frame
  logic [FALL_W-1:0] falls_q;
  // Cycles since the last sclk rise
  logic [4:0] since_q;
  // Cycles with select high
  logic [7:0] gap_q;
  // Last sclk level
  logic sclk_q;
  // Helper counters
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      falls_q <= '0;
      since_q <= 5'h1F;
      gap_q <= 8'hFF;
      sclk_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk;
      // Count falls only inside a frame
      if (frame_select_n)
        falls_q <= '0;
      else if (sclk_q && !sclk)
        falls_q <= falls_q + 1'b1;
      if (sclk && !sclk_q)
        since_q <= '0;
      else if (since_q != 5'h1F)
        since_q <= since_q + 1'b1;
      // Gap saturates so a long idle stays legal
      if (!frame_select_n)
        gap_q <= '0;
      else if (gap_q != 8'hFF)
        gap_q <= gap_q + 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  sclk_low_fall_a: assert property ($fell(frame_select_n) |-> !sclk)
    else $error("sclk high at select fall");
  sclk_low_rise_a: assert property ($rose(frame_select_n) |-> !sclk)
    else $error("sclk high at select rise");
  frame_gap_a: assert property ($fell(frame_select_n) |-> gap_q >= GAP_CYC)
    else $error("idle gap too short");
  sdo_released_a: assert property (frame_select_n [*6] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  oe_in_frame_a: assert property ($rose(sdo_oe) |-> !frame_select_n)
    else $error("sdo enabled outside frame");
  sdo_change_a: assert property (!frame_select_n && sdo_oe && $past(sdo_oe)
    && falls_q != '0 && $changed(sdo) |-> since_q <= 5'd6)
    else $error("sdo changed away from sclk rise");
  sdi_hold_a: assert property ($fell(sclk) |-> $stable(sdi) [*4])
    else $error("sdi moved at sclk fall");
  sclk_high_a: assert property ($rose(sclk) |=> sclk [*8])
    else $error("sclk high phase too short");
  bit_count_a: assert property ($rose(frame_select_n)
    |-> falls_q[3:0] == 4'h0 && falls_q != '0)
    else $error("frame not whole words");
  status_tag_a: assert property ($fell(sclk) && falls_q < 2 && sdo_oe |-> sdo_line)
    else $error("status tag bit not one");
  cover property ($rose(frame_select_n) && falls_q == 16);
  cover property ($rose(frame_select_n) && falls_q == 32);
  cover property ($rose(sdo_oe));
endmodule : mds_link_chk
`default_nettype wire

// *** sim/motor_driver_spi_slave_chain_bench.sv ***
// Bench joining host and device ends, plus a bench-driven second link.
// Assumes the register file and fault flags live in the bench.
`default_nettype none
module motor_driver_spi_slave_chain_bench
  import mds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_b, start, clear_all, sleep_request_n, tx_take, rx_valid;
  logic busy, done, reg_wr, reg_wr2, fault_clear, frame_error, frame_error2, tx_idx;
  logic [CHAIN_W-1:0] chain_len, chain_position, chain_length, pos2, len2;
  logic [7:0] tx_byte, rx_byte, reg_rdata, reg_wdata;
  logic [ADDR_W-1:0] reg_addr;
  logic [5:0] flags;
  // Register file, expected copy and payload buffer
  logic [7:0] regs [0:31];
  logic [7:0] shadow [0:31];
  logic [7:0] tx_buf [0:1];
  logic [7:0] exp_q [$];
  int mismatches, total_checks, clr_cnt, wr_cnt, err_cnt, wr2_cnt, err1_cnt;
  int seed = 32'h3020d75b;
  mds_link_if link();
  mds_link_if l2();
  assign reg_rdata = regs[reg_addr];
  assign tx_byte = tx_buf[tx_idx];
  mds_host_end mds_host_end_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus(link),
    .start(start), .chain_len(chain_len), .clear_all(clear_all), .tx_byte(tx_byte),
    .tx_take(tx_take), .rx_byte(rx_byte), .rx_valid(rx_valid), .busy(busy), .done(done));
  mds_dev_end mds_dev_end_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus(link),
    .sleep_request_n(sleep_request_n), .temp_warning_flag(flags[5]),
    .supply_low_flag(flags[4]), .pump_low_flag(flags[3]), .overcurrent_flag(flags[2]),
    .thermal_shutdown_flag(flags[1]), .open_load_flag(flags[0]), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .fault_clear(fault_clear), .frame_error(frame_error),
    .chain_position(chain_position), .chain_length(chain_length));
  // Second device, its link driven by the bench to break framing
  mds_dev_end mds_dev_end_inst_b (.sys_clk(sys_clk), .rst_b(rst_b), .bus(l2),
    .sleep_request_n(sleep_request_n), .temp_warning_flag(flags[5]),
    .supply_low_flag(flags[4]), .pump_low_flag(flags[3]), .overcurrent_flag(flags[2]),
    .thermal_shutdown_flag(flags[1]), .open_load_flag(flags[0]), .reg_addr(),
    .reg_rdata(8'h00), .reg_wr(reg_wr2), .reg_wdata(), .fault_clear(),
    .frame_error(frame_error2), .chain_position(pos2), .chain_length(len2));
  mds_link_chk mds_link_chk_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .frame_select_n(link.frame_select_n), .sclk(link.sclk), .sdi(link.sdi),
    .sdo(link.sdo), .sdo_oe(link.sdo_oe), .sdo_line(link.sdo_line));
  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : chk_byte
  task automatic chk_val(input string what, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : chk_val
  task automatic conclude();
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // Register file, payload pointer, strobe counters and received bytes
  always @(posedge sys_clk)
  begin
    if (reg_wr === 1'b1)
      regs[reg_addr] <= reg_wdata;
    if (tx_take === 1'b1)
      tx_idx <= ~tx_idx;
    if (reg_wr === 1'b1)
      wr_cnt++;
    if (fault_clear === 1'b1)
      clr_cnt++;
    if (frame_error2 === 1'b1)
      err_cnt++;
    if (frame_error === 1'b1)
      err1_cnt++;
    if (reg_wr2 === 1'b1)
      wr2_cnt++;
    if (rx_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk_byte("rx_extra", 8'h00, rx_byte);
      else
        chk_byte("rx_byte", exp_q.pop_front(), rx_byte);
    end
  end
  // One transfer: n = 0 single word, else chain of n with clear flag
  task automatic frame(input logic [CHAIN_W-1:0] n, input logic clr,
    input logic [7:0] cmd, input logic [7:0] dat);
    logic [31:0] r;
    int k;
    r = $random(seed);
    flags <= r[5:0];
    if (sleep_request_n !== 1'b1)
    begin
      exp_q.push_back(8'hFF);
      exp_q.push_back(8'hFF);
    end
    else
    begin
      exp_q.push_back({STATUS_TAG, r[5:0]});
      if (n != 0)
      begin
        exp_q.push_back({HDR_TAG, n});
        exp_q.push_back({HDR_TAG, clr, CHECK_PATTERN});
      end
      exp_q.push_back(shadow[cmd[5:1]]);
      if (!cmd[6])
        shadow[cmd[5:1]] = dat;
    end
    tx_buf[0] <= cmd;
    tx_buf[1] <= dat;
    tx_idx <= 1'b0;
    chain_len <= n;
    clear_all <= clr;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1; k++)
    begin
      @(posedge sys_clk);
      // Flags move mid-frame; the status byte must not
      if (k == 100)
      begin
        flags <= ~r[5:0];
        chk_val("busy", 16'h1, {15'h0, busy});
      end
    end
    chk_val("done", 16'h1, {15'h0, done});
    chk_val("busy_end", 16'h0, {15'h0, busy});
  endtask : frame
  // Bench-made frame of n clocks on the second link
  task automatic bang(input int n, input logic [47:0] w);
    int k;
    l2.frame_select_n <= 1'b0;
    repeat (30) @(posedge sys_clk);
    for (k = 0; k < n; k++)
    begin
      l2.sclk <= 1'b1;
      l2.sdi <= w[47-k];
      repeat (HALF_CYC) @(posedge sys_clk);
      l2.sclk <= 1'b0;
      repeat (HALF_CYC) @(posedge sys_clk);
    end
    repeat (HALF_CYC) @(posedge sys_clk);
    l2.frame_select_n <= 1'b1;
    l2.sdi <= ~l2.sdi;
    repeat (GAP_CYC) @(posedge sys_clk);
  endtask : bang
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
  // Main sequence
  initial
  begin
    logic [31:0] r;
    int i;
    rst_b = 1'b0;
    start = 1'b0;
    clear_all = 1'b0;
    chain_len = '0;
    sleep_request_n = 1'b1;
    flags = '0;
    tx_idx = 1'b0;
    tx_buf[0] = 8'h00;
    tx_buf[1] = 8'h00;
    l2.frame_select_n = 1'b1;
    l2.sclk = 1'b0;
    l2.sdi = 1'b0;
    for (i = 0; i < 32; i++)
    begin
      regs[i] = 8'($random(seed));
      shadow[i] = regs[i];
    end
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Write then read at both address ends
    for (i = 0; i < 2; i++)
    begin
      frame(0, 1'b0, {2'b00, 5'(i * 31), 1'b1}, 8'hA5);
      frame(0, 1'b0, {2'b01, 5'(i * 31), 1'b0}, 8'h3C);
    end
    // Random single words, back to back
    for (i = 0; i < 10; i++)
    begin
      r = $random(seed);
      frame(0, 1'b0, {1'b0, r[0], r[5:1], r[6]}, r[15:8]);
    end
    // Chain of one: write with clear-all, then read back without
    frame(1, 1'b1, {2'b00, 5'h0A, 1'b0}, 8'h96);
    chk_val("fault_clear", 16'h1, 16'(clr_cnt));
    chk_val("position", 16'h0, {10'h0, chain_position});
    chk_val("length", 16'h1, {10'h0, chain_length});
    frame(1, 1'b0, {2'b01, 5'h0A, 1'b0}, 8'h00);
    chk_val("fault_clear", 16'h1, 16'(clr_cnt));
    // Sleeping port ignores a write
    i = wr_cnt;
    sleep_request_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    frame(0, 1'b0, {2'b00, 5'h03, 1'b0}, 8'h11);
    chk_val("sleep_write", 16'(i), 16'(wr_cnt));
    sleep_request_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Short and long frames flag errors; a whole one writes
    i = wr_cnt;
    bang(15, {16'h2AA5, 32'h0});
    bang(17, {16'h2AA5, 32'h0});
    bang(16, {16'h2AA5, 32'h0});
    // Second in a chain of two: one status byte ahead of the headers
    bang(48, {8'hC5, 8'h82, 8'h95, 8'h0E, 8'h00, 8'h5A});
    chk_val("frame_error", 16'h2, 16'(err_cnt));
    chk_val("whole_write", 16'h2, 16'(wr2_cnt));
    chk_val("position_b", 16'h1, {10'h0, pos2});
    chk_val("length_b", 16'h2, {10'h0, len2});
    chk_val("host_frame_error", 16'h0, 16'(err1_cnt));
    chk_val("other_select", 16'(i), 16'(wr_cnt));
    chk_val("pending", 16'h0, 16'(exp_q.size()));
    conclude();
  end
endmodule : motor_driver_spi_slave_chain_bench
`default_nettype wire
